// file: include/ags_pkg.sv
// constants and carrier types for the autorange gate selector
package ags_pkg;

  // gate ranges, index equals the digit slot that selects it on the range input
  localparam logic [1:0] AGS_RANGE_10MS = 2'h0;
  localparam logic [1:0] AGS_RANGE_100MS = 2'h1;
  localparam logic [1:0] AGS_RANGE_1S = 2'h2;
  localparam logic [1:0] AGS_RANGE_10S = 2'h3;

  // slot positions within the eight digit-slot lines
  localparam int AGS_SLOTS = 8;
  localparam int AGS_DIGITS = 6;
  localparam int AGS_FIRST_SLOT = 0;
  localparam int AGS_MSD_SLOT = 5;
  localparam int AGS_OVF_SLOT = 6;

  localparam logic [3:0] AGS_BCD_ZERO = 4'h0;
  localparam logic [3:0] AGS_BCD_NINE = 4'h9;
  localparam logic [3:0] AGS_BCD_EIGHT = 4'h8;

  // mid-slot strobe delay
  localparam int AGS_STROBE_US = 125;
  localparam int AGS_CLK_MHZ = 40;
  localparam int AGS_STROBE_CYC_INT = AGS_STROBE_US * AGS_CLK_MHZ;
  localparam int AGS_CNT_W = 13;
  localparam logic [AGS_CNT_W-1:0] AGS_STROBE_CYC_DEF = AGS_CNT_W'(AGS_STROBE_CYC_INT);
  localparam logic [AGS_CNT_W-1:0] AGS_CNT_ONE = 13'h0001;
  localparam logic [AGS_CNT_W-1:0] AGS_CNT_ZERO = 13'h0000;

  // lines from the counting chip
  typedef struct packed {
    logic [AGS_SLOTS-1:0] slot;
    logic [3:0] bcd;
    logic seg_b;
    logic seg_f;
    logic dp;
    logic store;
  } ags_chip_t;

  // front-panel switches
  typedef struct packed {
    logic auto_range;
    logic [1:0] gate_time_selector;
    logic hold;
    logic reset_btn;
    logic event_accumulate_function;
    logic event_in;
  } ags_panel_t;

  typedef struct packed {
    ags_chip_t c1;
    ags_chip_t c2;
    ags_panel_t p1;
    ags_panel_t p2;
    logic [AGS_SLOTS-1:0] slot_prev;
    logic store_prev;
    logic event_prev;
    logic [AGS_CNT_W-1:0] msd_cnt;
    logic [AGS_CNT_W-1:0] ovf_cnt;
    logic msd_blank;
    logic [1:0] range;
    logic [AGS_DIGITS*4-1:0] tot;
    logic tot_ovf;
    logic [AGS_DIGITS*4-1:0] disp;
    logic [AGS_DIGITS-1:0] disp_dp;
    logic [AGS_DIGITS-1:0] digit_en;
    logic range_slot;
    logic [1:0] range_code;
    logic lamp;
    logic display_test;
  } ags_state_t;

endpackage

// file: testbench/ags_autorange_gate_selector_tb.sv
// self-checking bench for the autorange gate selector
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module ags_autorange_gate_selector_tb;
  import ags_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] msd_val = 4'h0;
  logic ovf = 1'b0;
  ags_chip_t chip;
  ags_panel_t panel = '0;
  logic range_slot;
  logic [1:0] range_code;
  logic overflow_lamp;
  logic [23:0] disp_digits;
  logic [5:0] disp_points;
  logic [5:0] digit_enable;
  logic display_test;
  int error_cnt = 0;
  int n_checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  ags_chip_model u_chip (.sys_clk(sys_clk), .msd_val(msd_val), .ovf(ovf), .chip(chip));
  ags_autorange_gate_selector #(.STROBE_CYC(13'h0004)) u_dut (.sys_clk(sys_clk), .rstn(rstn),
    .chip_in(chip), .panel_in(panel), .range_slot(range_slot), .range_code(range_code),
    .overflow_lamp(overflow_lamp), .disp_digits(disp_digits), .disp_points(disp_points),
    .digit_enable(digit_enable), .display_test(display_test));
  ////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // frame is 102 cycles, so a range step lands well inside four frames
  task automatic wait_code(input logic [1:0] exp);
    int i;
    for (i = 0; i < 400 && range_code !== exp; i++)
      @(negedge sys_clk);
    if (i == 400)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, range_code, exp);
      finish_test();
    end
  endtask
  task automatic frames(input int n);
    repeat (n * 102) @(negedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic s_climb();
    `CHK(range_code, AGS_RANGE_10MS)
    wait_code(AGS_RANGE_100MS);
    wait_code(AGS_RANGE_1S);
    frames(4);
    `CHK(range_code, AGS_RANGE_1S)
    `CHK(range_slot, 1'b0)
  endtask
  task automatic s_overflow();
    int i;
    ovf = 1'b1;
    for (i = 0; i < 400 && overflow_lamp !== 1'b1; i++)
      @(negedge sys_clk);
    `CHK(overflow_lamp, 1'b1)
    if (i == 400)
      finish_test();
    wait_code(AGS_RANGE_10MS);
    ovf = 1'b0;
    // top digit filled from the next frame on, so the climb stops at 0.1 s
    msd_val = 4'h5;
    frames(1);
    `CHK(overflow_lamp, 1'b0)
    wait_code(AGS_RANGE_100MS);
  endtask
  task automatic s_filled_hold();
    msd_val = 4'h5;
    frames(4);
    `CHK(range_code, AGS_RANGE_100MS)
    `CHK(disp_digits, 24'h543210)
    `CHK(disp_points, 6'h01)
    panel.hold = 1'b1;
    frames(1);
    msd_val = 4'h7;
    frames(2);
    `CHK(disp_digits, 24'h543210)
    panel.hold = 1'b0;
    frames(2);
    `CHK(disp_digits, 24'h743210)
    // land inside the second digit slot of a frame
    repeat (42) @(negedge sys_clk);
    `CHK(digit_enable, 6'h02)
    `CHK(range_slot, 1'b1)
  endtask
  task automatic s_manual();
    panel.auto_range = 1'b0;
    panel.gate_time_selector = AGS_RANGE_10S;
    wait_code(AGS_RANGE_10S);
    panel.auto_range = 1'b1;
    wait_code(AGS_RANGE_10MS);
  endtask
  task automatic s_accumulate();
    panel.reset_btn = 1'b1;
    frames(1);
    `CHK(disp_digits, 24'h888888)
    `CHK(disp_points, 6'h3f)
    `CHK(display_test, 1'b1)
    `CHK(digit_enable, 6'h3f)
    panel.reset_btn = 1'b0;
    panel.event_accumulate_function = 1'b1;
    repeat (12)
    begin
      repeat (3) @(negedge sys_clk);
      panel.event_in = 1'b1;
      repeat (3) @(negedge sys_clk);
      panel.event_in = 1'b0;
    end
    frames(2);
    `CHK(disp_digits, 24'h000012)
    `CHK(overflow_lamp, 1'b0)
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    panel.auto_range = 1'b1;
    repeat (12) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
    s_climb();
    s_overflow();
    s_filled_hold();
    s_manual();
    s_accumulate();
    finish_test();
  end
endmodule // ags_autorange_gate_selector_tb

// file: testbench/ags_chip_model.sv
// counting chip model: digit slots, digit values, overflow segment and store pulse
`timescale 1ns/1ps
module ags_chip_model
  import ags_pkg::*;
#(
  parameter int SLOT_W = 12
)
(
  input wire logic sys_clk,
  input wire logic [3:0] msd_val,
  input wire logic ovf,
  output ags_chip_t chip
);
  int cyc = 0;
  int k = 0;
  initial chip = '0;
  ////////////////////////////////////////////////////////////
  always @(negedge sys_clk)
  begin
    k = cyc / SLOT_W;
    chip.slot <= (k < AGS_SLOTS) ? 8'h01 << k : 8'h00;
    // between frames the digit lines carry junk, not the last digit
    chip.bcd <= (k >= AGS_SLOTS) ? ~chip.bcd : (k == AGS_MSD_SLOT) ? msd_val : 4'(k);
    chip.seg_b <= ovf && (k == AGS_OVF_SLOT);
    chip.seg_f <= 1'b0;
    chip.dp <= (k == AGS_FIRST_SLOT);
    chip.store <= (k == AGS_SLOTS);
    cyc = (cyc == AGS_SLOTS * SLOT_W + 5) ? 0 : cyc + 1;
  end
endmodule // ags_chip_model

// file: verilog/ags_autorange_gate_selector.sv
// autorange gate selector, overflow lamp and display latch
`timescale 1ns/1ps
module ags_autorange_gate_selector
  import ags_pkg::*;
#(
  parameter logic [AGS_CNT_W-1:0] STROBE_CYC = AGS_STROBE_CYC_DEF
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire ags_chip_t chip_in,
  input wire ags_panel_t panel_in,
  output logic range_slot,
  output logic [1:0] range_code,
  output logic overflow_lamp,
  output logic [AGS_DIGITS*4-1:0] disp_digits,
  output logic [AGS_DIGITS-1:0] disp_points,
  output logic [AGS_DIGITS-1:0] digit_enable,
  output logic display_test
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  assign rst_n = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [4:0] bcd_step(input logic [3:0] d, input logic c);
    logic [4:0] r;
    r = {1'b0, d};
    if (c)
    begin
      if (d == AGS_BCD_NINE)
        r = {1'b1, AGS_BCD_ZERO};
      else
        r = {1'b0, 4'(d + 4'h1)};
    end
    return r;
  endfunction

  function automatic logic [AGS_CNT_W-1:0] strobe_next(input logic rise,
      input logic [AGS_CNT_W-1:0] cnt, input logic [AGS_CNT_W-1:0] load);
    logic [AGS_CNT_W-1:0] n;
    n = cnt;
    if (rise)
      n = load;
    else if (cnt != AGS_CNT_ZERO)
      n = AGS_CNT_W'(cnt - AGS_CNT_ONE);
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  ags_state_t st_r;
  ags_state_t st_nxt;

  logic [AGS_SLOTS-1:0] ts;
  logic msd_rise;
  logic ovf_rise;
  logic msd_fire;
  logic ovf_fire;
  logic ovf_hit;
  logic store_rise;
  logic event_rise;
  logic [1:0] eff_range;

  assign ts = st_r.c2.slot;
  assign msd_rise = ts[AGS_MSD_SLOT] & ~st_r.slot_prev[AGS_MSD_SLOT];
  assign ovf_rise = ts[AGS_OVF_SLOT] & ~st_r.slot_prev[AGS_OVF_SLOT];
  assign msd_fire = (st_r.msd_cnt == AGS_CNT_ONE);
  assign ovf_fire = (st_r.ovf_cnt == AGS_CNT_ONE);
  // overflow shows as segment b or f lit in the seventh slot
  assign ovf_hit = ovf_fire & ts[AGS_OVF_SLOT] & (st_r.c2.seg_b | st_r.c2.seg_f);
  assign store_rise = st_r.c2.store & ~st_r.store_prev;
  assign event_rise = st_r.p2.event_in & ~st_r.event_prev;
  // manual setting reaches the chip unrestricted, 10 s included
  assign eff_range = st_r.p2.auto_range ? st_r.range : st_r.p2.gate_time_selector;

  always_comb
  begin
    logic [4:0] step;
    logic carry;
    step = 5'h00;
    carry = 1'b0;
    st_nxt = st_r;
    // two-stage synchronisers; stage one feeds stage two only
    st_nxt.c1 = chip_in;
    st_nxt.c2 = st_r.c1;
    st_nxt.p1 = panel_in;
    st_nxt.p2 = st_r.p1;
    st_nxt.slot_prev = ts;
    st_nxt.store_prev = st_r.c2.store;
    st_nxt.event_prev = st_r.p2.event_in;

    st_nxt.msd_cnt = strobe_next(msd_rise, st_r.msd_cnt, STROBE_CYC);
    st_nxt.ovf_cnt = strobe_next(ovf_rise, st_r.ovf_cnt, STROBE_CYC);
    if (msd_fire)
      st_nxt.msd_blank = (st_r.c2.bcd == AGS_BCD_ZERO);

    // range stepping; overflow fallback outranks a store in the same cycle
    if (!st_r.p2.auto_range)
    begin
      st_nxt.range = AGS_RANGE_10MS;
      st_nxt.msd_blank = 1'b0;
    end
    else if (ovf_hit)
      st_nxt.range = AGS_RANGE_10MS;
    else if (store_rise && st_r.msd_blank && st_r.range != AGS_RANGE_1S)
      st_nxt.range = 2'(st_r.range + 2'h1);
    // otherwise a filled digit or the 1 s ceiling keeps the gate

    // accumulate: six bcd digits with carry
    if (st_r.p2.event_accumulate_function && event_rise && !st_r.p2.reset_btn)
    begin
      carry = 1'b1;
      for (int k = 0; k < AGS_DIGITS; k++)
      begin
        step = bcd_step(st_r.tot[k*4 +: 4], carry);
        st_nxt.tot[k*4 +: 4] = step[3:0];
        carry = step[4];
      end
    end
    if (st_r.p2.reset_btn)
      st_nxt.tot = '0;
    // the clear blocks counting, so it always wins over a wrap out of the top digit
    st_nxt.tot_ovf = carry | (st_r.tot_ovf & ~st_r.p2.reset_btn);

    // display latch: a digit is taken while its slot is active
    for (int k = 0; k < AGS_DIGITS; k++)
    begin
      if (st_r.p2.reset_btn)
      begin
        st_nxt.disp[k*4 +: 4] = AGS_BCD_EIGHT;
        st_nxt.disp_dp[k] = 1'b1;
      end
      else if (!st_r.p2.hold && ts[k])
      begin
        st_nxt.disp[k*4 +: 4] = st_r.p2.event_accumulate_function ? st_r.tot[k*4 +: 4] : st_r.c2.bcd;
        st_nxt.disp_dp[k] = st_r.c2.dp;
      end
    end

    st_nxt.digit_en = st_r.p2.reset_btn ? '1 : ts[AGS_DIGITS-1:0];
    st_nxt.range_slot = ts[eff_range];
    st_nxt.range_code = eff_range;
    st_nxt.lamp = (ts[AGS_OVF_SLOT] & (st_r.c2.seg_b | st_r.c2.seg_f)) | st_r.tot_ovf;
    st_nxt.display_test = st_r.p2.reset_btn;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign range_slot = st_r.range_slot;
  assign range_code = st_r.range_code;
  assign overflow_lamp = st_r.lamp;
  assign disp_digits = st_r.disp;
  assign disp_points = st_r.disp_dp;
  assign digit_enable = st_r.digit_en;
  assign display_test = st_r.display_test;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_range_ceiling: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_r.range != AGS_RANGE_10S) else $error("auto range reached 10 s gate");

  a_filled_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_r.p2.auto_range && !st_r.msd_blank && !ovf_hit) |=> $stable(st_r.range))
    else $error("range moved with top digit filled");

  a_blank_advance: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_r.p2.auto_range && store_rise && st_r.msd_blank && !ovf_hit && st_r.range == AGS_RANGE_10MS)
    |=> st_r.range == AGS_RANGE_100MS) else $error("blank digit did not step range");

  a_top_repeat: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_r.p2.auto_range && st_r.range == AGS_RANGE_1S && !ovf_hit) |=> st_r.range == AGS_RANGE_1S)
    else $error("range left 1 s gate without overflow");

  a_ovf_fallback: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ovf_hit |=> (st_r.range == AGS_RANGE_10MS) ##1 (st_r.range_code == AGS_RANGE_10MS))
    else $error("overflow did not restore shortest gate");

  a_ovf_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ovf_rise |=> st_r.ovf_cnt == STROBE_CYC) else $error("overflow strobe not armed");

  a_msd_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
    msd_rise |=> (st_r.msd_cnt == STROBE_CYC) ##1 (st_r.msd_cnt == STROBE_CYC - AGS_CNT_ONE) or msd_rise)
    else $error("blank strobe not counting");

  a_lamp_slot: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ts[AGS_OVF_SLOT] && (st_r.c2.seg_b || st_r.c2.seg_f)) |=> overflow_lamp)
    else $error("overflow lamp missed slot seven");

  a_auto_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !st_r.p2.auto_range |=> st_r.range == AGS_RANGE_10MS) else $error("range not cleared outside auto");

  a_test_eights: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_r.p2.reset_btn |=> (disp_digits == {AGS_DIGITS{AGS_BCD_EIGHT}}) && (&disp_points) && display_test)
    else $error("display test pattern missing");

  a_hold_freeze: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_r.p2.hold && !st_r.p2.reset_btn) |=> $stable(disp_digits)) else $error("display moved in hold");

endmodule // ags_autorange_gate_selector
